// ==== hdl/hcr_flag_if.sv ====
// Purpose: carries set, clear and flag vectors of one status register
// Assumes: all signals on the system clock
// Notes: owner holds the flags, user raises sets and clears
`timescale 1ns/1ps
interface hcr_flag_if #(parameter int W = 8);
  logic [W-1:0] set; // Event pulses, one bit per source
  logic [W-1:0] clr; // Write-one-to-clear strobes
  logic [W-1:0] flags; // Sticky flags
  modport owner (input set, input clr, output flags);
  modport user (output set, output clr, input flags);
endinterface

// ==== hdl/hcr_pkg.sv ====
// Purpose: constants for the converter config and interrupt register bank
// Assumes: 8-bit registers at small byte offsets, one system clock
// Notes: every offset, bit position and reset value lives here
//
// How it works
// - Port bit 7 selects three-wire mode
// - Port bit 6 selects LSB-first order
// - Writing port bit 5 starts software reset
// - Port bits 3..0 mirror bits 4..7
// - Power bit 7 powers down bandgap
// - Reference current down forces zero full scale
// - Bias power-down switches off bias currents
// - Power bit 2 powers down clock path
// - Retimer power-down stops retimer PLL
// - Receiver loop power-down stops receiver DLL
// - Lower enable gates seven sources, bit 4 reserved
// - Status bits 7/6 flag FIFO near overwrite
// - Status bit 5 on acknowledge rising edge
// - Status bits 3/2 flag DLL warn, lock
// - Status bits 1/0 flag retimer lost, lock
// - Upper enable gates five sources, low reserved
// - Checker pass after eight valid samples
// - Checker fail bits set on miscompare
// - Parity faults split by falling, rising edge
package hcr_pkg;
  // ----------------------------------------
  // Register port
  // ----------------------------------------
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [6:0] OFF_PORT = 7'h00;
  localparam logic [6:0] OFF_PWR = 7'h01;
  localparam logic [6:0] OFF_IEN_LO = 7'h03;
  localparam logic [6:0] OFF_IEN_HI = 7'h04;
  localparam logic [6:0] OFF_IST_LO = 7'h05;
  localparam logic [6:0] OFF_IST_HI = 7'h06;
  localparam logic [6:0] OFF_FRAME = 7'h07;
  // ----------------------------------------
  // Reset values and writable masks
  // ----------------------------------------
  localparam logic [7:0] RST_PORT = 8'h81;
  localparam logic [7:0] RST_PWR = 8'h48;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] IEN_LO_MASK = 8'hef;
  localparam logic [7:0] IEN_HI_MASK = 8'hfc;
  localparam logic [7:0] IST_LO_MASK = 8'hef;
  localparam logic [7:0] IST_HI_MASK = 8'h7c;
  localparam logic [7:0] FRAME_MASK = 8'h03;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PORT_DIR = 7;
  localparam int PORT_ORDER = 6;
  localparam int PORT_SRST = 5;
  localparam int PWR_BG = 7;
  localparam int PWR_IREF = 6;
  localparam int PWR_BIAS = 5;
  localparam int PWR_CLK = 2;
  localparam int PWR_RET = 1;
  localparam int PWR_DLL = 0;
  localparam int ST_WARN2 = 7;
  localparam int ST_WARN1 = 6;
  localparam int ST_ACK = 5;
  localparam int ST_DLLW = 3;
  localparam int ST_DLLL = 2;
  localparam int ST_RLOST = 1;
  localparam int ST_RLOCK = 0;
  localparam int ST_APASS = 6;
  localparam int ST_AFAIL = 5;
  localparam int ST_SFAIL = 4;
  localparam int ST_PARF = 3;
  localparam int ST_PARR = 2;
  // ----------------------------------------
  // Counts and widths
  // ----------------------------------------
  localparam int AED_SAMPLES = 8;
  localparam int FSC_W = 10;
endpackage

// ==== hdl/hcr_regs.sv ====
// Purpose: configuration and interrupt register bank of the converter
// Assumes: the serial engine delivers decoded accesses on this clock
// Notes: event inputs come from datapath logic on the same clock
`timescale 1ns/1ps
module hcr_regs import hcr_pkg::*; #(
  parameter int FW = FSC_W
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  // Register access from the serial engine
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [DATA_W-1:0] reg_rdata_o,
  output logic reg_rvalid_o,
  // Event sources
  input wire logic fifo_two_slot_warning_i,
  input wire logic fifo_one_slot_warning_i,
  input wire logic serial_frame_acknowledge_i,
  input wire logic dll_warning_i,
  input wire logic dll_lock_i,
  input wire logic retimer_lost_i,
  input wire logic retimer_lock_i,
  input wire logic automatic_error_checker_enable_i,
  input wire logic automatic_error_checker_valid_i,
  input wire logic automatic_error_checker_fail_i,
  input wire logic sample_error_checker_fail_i,
  input wire logic parity_fall_error_i,
  input wire logic parity_rise_error_i,
  input wire logic [FW-1:0] full_scale_code_i,
  // Controls
  output logic three_wire_mode_o,
  output logic lsb_first_o,
  output logic software_reset_o,
  output logic bandgap_power_down_o,
  output logic bias_power_down_o,
  output logic clock_path_power_down_o,
  output logic retimer_pll_power_down_o,
  output logic receiver_loop_power_down_o,
  output logic [FW-1:0] full_scale_current_o,
  output logic [1:0] frame_pin_mode_o,
  output logic interrupt_request_o
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [3:0] port_q; // Port bits 7,6,5,4; bit 5 unused here
  logic srst_q; // Software reset in progress
  logic [7:0] pwr_q; // Power-down controls
  logic [7:0] ien_lo_q; // Lower enables
  logic [7:0] ien_hi_q; // Upper enables
  logic [1:0] frame_q; // Frame pin mode field
  logic ack_q; // Last acknowledge level
  logic [FW-1:0] fsc_q; // Gated full-scale code
  logic irq_q; // Combined request
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic aed_pass; // Pulse from the sample tally
  logic wr_port, wr_pwr, wr_ien_lo, wr_ien_hi, wr_frame;

  hcr_flag_if #(.W(8)) st_lo ();
  hcr_flag_if #(.W(8)) st_hi ();

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Address match for one offset; the config write strobes below are ignored while soft reset runs
  function automatic logic hit(input logic [6:0] a, input logic [6:0] off);
    hit = (a == off);
  endfunction

  // Port byte with its safety mirror in the low nibble
  function automatic logic [7:0] port_byte(input logic [3:0] hi);
    port_byte = {hi, hi[0], hi[1], hi[2], hi[3]};
  endfunction

  assign wr_port = reg_wr_i && !srst_q && hit(reg_addr_i, OFF_PORT);
  assign wr_pwr = reg_wr_i && !srst_q && hit(reg_addr_i, OFF_PWR);
  assign wr_ien_lo = reg_wr_i && !srst_q && hit(reg_addr_i, OFF_IEN_LO);
  assign wr_ien_hi = reg_wr_i && !srst_q && hit(reg_addr_i, OFF_IEN_HI);
  assign wr_frame = reg_wr_i && !srst_q && hit(reg_addr_i, OFF_FRAME);

  // ----------------------------------------
  // Port mode register
  // ----------------------------------------
  // Bit 4 is stored as written; the host is meant to keep it zero
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      port_q <= RST_PORT[7:4];
    end else if (srst_q) begin
      port_q <= RST_PORT[7:4];
    end else if (wr_port) begin
      port_q <= {reg_wdata_i[7:6], 1'b0, reg_wdata_i[4]};
    end
  end

  // One-cycle soft reset; the next cycle restores every register
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= wr_port && reg_wdata_i[PORT_SRST];
    end
  end

  // ----------------------------------------
  // Power-down and enable registers
  // ----------------------------------------
  // Reserved power bits are kept as written
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pwr_q <= RST_PWR;
    end else if (srst_q) begin
      pwr_q <= RST_PWR;
    end else if (wr_pwr) begin
      pwr_q <= reg_wdata_i;
    end
  end

  // Reserved read-only enable bits stay zero through the masks
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ien_lo_q <= RST_ZERO;
      ien_hi_q <= RST_ZERO;
      frame_q <= '0;
    end else if (srst_q) begin
      ien_lo_q <= RST_ZERO;
      ien_hi_q <= RST_ZERO;
      frame_q <= '0;
    end else begin
      if (wr_ien_lo) begin
        ien_lo_q <= reg_wdata_i & IEN_LO_MASK;
      end
      if (wr_ien_hi) begin
        ien_hi_q <= reg_wdata_i & IEN_HI_MASK;
      end
      if (wr_frame) begin
        frame_q <= reg_wdata_i[1:0];
      end
    end
  end

  // ----------------------------------------
  // Event capture
  // ----------------------------------------
  // Acknowledge is a level; only its rising edge is an event
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= serial_frame_acknowledge_i;
    end
  end

  hcr_sample_tally #(.N(AED_SAMPLES)) u_tally (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .clr_i(!automatic_error_checker_enable_i || srst_q),
    .valid_i(automatic_error_checker_valid_i),
    .pass_o(aed_pass)
  );

  // Lower status sources
  always_comb begin
    st_lo.set = '0;
    st_lo.set[ST_WARN2] = fifo_two_slot_warning_i;
    st_lo.set[ST_WARN1] = fifo_one_slot_warning_i;
    st_lo.set[ST_ACK] = serial_frame_acknowledge_i && !ack_q;
    st_lo.set[ST_DLLW] = dll_warning_i;
    st_lo.set[ST_DLLL] = dll_lock_i;
    st_lo.set[ST_RLOST] = retimer_lost_i;
    st_lo.set[ST_RLOCK] = retimer_lock_i;
  end

  // Upper status sources
  always_comb begin
    st_hi.set = '0;
    st_hi.set[ST_APASS] = aed_pass;
    st_hi.set[ST_AFAIL] = automatic_error_checker_fail_i;
    st_hi.set[ST_SFAIL] = sample_error_checker_fail_i;
    st_hi.set[ST_PARF] = parity_fall_error_i;
    st_hi.set[ST_PARR] = parity_rise_error_i;
  end

  // Software clears a flag by writing one to it
  assign st_lo.clr = (reg_wr_i && hit(reg_addr_i, OFF_IST_LO)) ? reg_wdata_i : '0;
  assign st_hi.clr = (reg_wr_i && hit(reg_addr_i, OFF_IST_HI)) ? reg_wdata_i : '0;

  hcr_sticky_flags #(.W(8), .MASK(IST_LO_MASK)) u_st_lo (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .srst_i(srst_q),
    .fl(st_lo)
  );

  hcr_sticky_flags #(.W(8), .MASK(IST_HI_MASK)) u_st_hi (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .srst_i(srst_q),
    .fl(st_hi)
  );

  // ----------------------------------------
  // Interrupt and current gating
  // ----------------------------------------
  // Registered, so the request trails the flag by one cycle
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |((st_lo.flags & ien_lo_q) | (st_hi.flags & ien_hi_q));
    end
  end

  // Full-scale code is held at zero while reference current is down
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      fsc_q <= '0;
    end else if (pwr_q[PWR_IREF]) begin
      fsc_q <= '0;
    end else begin
      fsc_q <= full_scale_code_i;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Unmapped offsets read zero; data valid one cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= RST_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          OFF_PORT: rdata_q <= port_byte({port_q[3:2], srst_q, port_q[0]});
          OFF_PWR: rdata_q <= pwr_q;
          OFF_IEN_LO: rdata_q <= ien_lo_q;
          OFF_IEN_HI: rdata_q <= ien_hi_q;
          OFF_IST_LO: rdata_q <= st_lo.flags;
          OFF_IST_HI: rdata_q <= st_hi.flags;
          OFF_FRAME: rdata_q <= {6'h00, frame_q} & FRAME_MASK;
          default: rdata_q <= RST_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;
  assign three_wire_mode_o = port_q[3];
  assign lsb_first_o = port_q[2];
  assign software_reset_o = srst_q;
  assign bandgap_power_down_o = pwr_q[PWR_BG];
  assign bias_power_down_o = pwr_q[PWR_BIAS];
  assign clock_path_power_down_o = pwr_q[PWR_CLK];
  assign retimer_pll_power_down_o = pwr_q[PWR_RET];
  assign receiver_loop_power_down_o = pwr_q[PWR_DLL];
  assign full_scale_current_o = fsc_q;
  assign frame_pin_mode_o = frame_q;
  assign interrupt_request_o = irq_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_srst_req;
    wr_port && reg_wdata_i[PORT_SRST];
  endsequence
  sequence s_srst_done;
    software_reset_o ##1 (!software_reset_o && three_wire_mode_o && !lsb_first_o);
  endsequence

  chk_dir_write: assert property (wr_port && !reg_wdata_i[PORT_SRST] |=>
    three_wire_mode_o == $past(reg_wdata_i[PORT_DIR])) else $error("mode bit lost");
  chk_order_write: assert property (wr_port && !reg_wdata_i[PORT_SRST] |=>
    lsb_first_o == $past(reg_wdata_i[PORT_ORDER])) else $error("order bit lost");
  chk_soft_reset: assert property (s_srst_req |=> s_srst_done)
    else $error("soft reset sequence wrong");
  chk_srst_restore: assert property (software_reset_o |=> pwr_q == RST_PWR &&
    ien_lo_q == RST_ZERO && st_hi.flags == RST_ZERO) else $error("reset values lost");
  chk_port_mirror: assert property (reg_rd_i && reg_addr_i == OFF_PORT |=>
    reg_rvalid_o && reg_rdata_o[3:0] == {reg_rdata_o[4], reg_rdata_o[5],
    reg_rdata_o[6], reg_rdata_o[7]}) else $error("mirror mismatch");
  chk_power_write: assert property (wr_pwr |=> {bandgap_power_down_o,
    bias_power_down_o, clock_path_power_down_o, retimer_pll_power_down_o,
    receiver_loop_power_down_o} == $past({reg_wdata_i[7], reg_wdata_i[5],
    reg_wdata_i[2:0]})) else $error("power control not applied");
  chk_fsc_forced: assert property (pwr_q[PWR_IREF] |=> full_scale_current_o == '0)
    else $error("current not forced off");
  chk_fsc_pass: assert property (!pwr_q[PWR_IREF] |=>
    full_scale_current_o == $past(full_scale_code_i)) else $error("current not applied");
  chk_en_reserved: assert property (!ien_lo_q[4] && ien_hi_q[1:0] == 2'b00)
    else $error("reserved enable set");
  chk_ack_edge: assert property (!srst_q && serial_frame_acknowledge_i && !ack_q |=>
    st_lo.flags[ST_ACK]) else $error("ack edge missed");
  chk_ack_level: assert property (!srst_q && $stable(st_lo.flags) ##1
    serial_frame_acknowledge_i && ack_q && st_lo.clr[ST_ACK] |=> !st_lo.flags[ST_ACK])
    else $error("ack level set flag");
  chk_lock_flags: assert property (!srst_q && retimer_lost_i && dll_warning_i |=>
    st_lo.flags[ST_RLOST] && st_lo.flags[ST_DLLW]) else $error("lock flag missed");
  chk_parity_split: assert property (!srst_q && parity_fall_error_i &&
    !parity_rise_error_i && st_hi.flags[ST_PARR] == 1'b0 |=> st_hi.flags[ST_PARF] &&
    !st_hi.flags[ST_PARR]) else $error("parity edge mixed");
  chk_irq_gate: assert property (
    (|((st_lo.flags & ien_lo_q) | (st_hi.flags & ien_hi_q))) |=> interrupt_request_o)
    else $error("request missing");
  chk_irq_quiet: assert property ((st_lo.flags & ien_lo_q) == '0 &&
    (st_hi.flags & ien_hi_q) == '0 |=> !interrupt_request_o) else $error("stray request");
endmodule

// ==== hdl/hcr_sample_tally.sv ====
// Purpose: counts valid samples of the automatic checker
// Assumes: valid is a one-cycle strobe per captured sample
// Notes: pass pulses once per enable period, then holds off
`timescale 1ns/1ps
module hcr_sample_tally import hcr_pkg::*; #(
  parameter int N = AED_SAMPLES
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic clr_i,
  input wire logic valid_i,
  output logic pass_o
);
  localparam int CW = $clog2(N + 1);
  localparam logic [CW-1:0] LAST = CW'(N - 1);
  localparam logic [CW-1:0] FULL = CW'(N);
  logic [CW-1:0] cnt_q; // Samples seen since enable
  logic pass_q;

  // ----------------------------------------
  // Tally
  // ----------------------------------------
  // Saturates at N so a long run does not pass twice
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
      pass_q <= 1'b0;
    end else begin
      pass_q <= 1'b0;
      if (clr_i) begin
        cnt_q <= '0;
      end else if (valid_i && cnt_q != FULL) begin
        cnt_q <= cnt_q + 1'b1;
        pass_q <= (cnt_q == LAST);
      end
    end
  end
  assign pass_o = pass_q;

  chk_pass_eighth: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    pass_q |-> $past(cnt_q) == LAST && cnt_q == FULL)
    else $error("pass without eighth sample");
endmodule

// ==== hdl/hcr_sticky_flags.sv ====
// Purpose: sticky status flags with write-one-to-clear
// Assumes: set and clear come from the same clock
// Notes: a set in the clearing cycle wins, soft reset wins over both
`timescale 1ns/1ps
module hcr_sticky_flags import hcr_pkg::*; #(
  parameter int W = 8,
  parameter logic [7:0] MASK = 8'hff
) (
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic srst_i,
  hcr_flag_if.owner fl
);
  logic [W-1:0] flags_q;

  // ----------------------------------------
  // Flag storage
  // ----------------------------------------
  // Unused positions never set, so reserved bits read zero
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_q <= '0;
    end else if (srst_i) begin
      flags_q <= '0;
    end else begin
      flags_q <= ((flags_q & ~fl.clr) | fl.set) & MASK[W-1:0];
    end
  end
  assign fl.flags = flags_q;

  chk_set_wins: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
    !srst_i && (fl.set & MASK[W-1:0]) != '0 |=> (flags_q & $past(fl.set & MASK[W-1:0]))
    == $past(fl.set & MASK[W-1:0])) else $error("flag set lost");
endmodule

// ==== tb/hcr_host_model.sv ====
// Purpose: serial host stand-in that issues register reads and writes
// Assumes: requests launch and release on falling edges of the clock
// Notes: an idle bus shows inverted last values, so stale data never matches
`timescale 1ns/1ps
module hcr_host_model import hcr_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic [DATA_W-1:0] rdata_i,
  input wire logic rvalid_i,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // Quiet bus at time zero
  initial begin
    addr_o = 7'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // One-cycle write strobe; reserved bits are kept as the device expects
  task automatic write_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] v;
    v = d;
    if (a == OFF_PORT) v[4] = 1'b0;
    if (a == OFF_PWR) v[3] = 1'b1;
    @(negedge clk_sys_i);
    addr_o = a;
    wdata_o = v;
    wr_o = 1'b1;
    @(negedge clk_sys_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~v;
  endtask

  // One-cycle read strobe; the answer is taken while its valid pulse stands
  task automatic read_reg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                          output logic ok);
    @(negedge clk_sys_i);
    addr_o = a;
    rd_o = 1'b1;
    // Valid stands only for the cycle after the strobe edge, so take it here
    @(negedge clk_sys_i);
    ok = rvalid_i;
    d = rdata_i;
    rd_o = 1'b0;
    addr_o = ~a;
    @(negedge clk_sys_i);
  endtask
endmodule

// ==== tb/tb.sv ====
// Purpose: self-checking bench for the config and interrupt register bank
// Assumes: host model drives the register port, bench drives events
// Notes: ordinary accesses come from a table, events and resets by hand
`timescale 1ns/1ps
module tb;
  import hcr_pkg::*;
  typedef struct {logic [6:0] a; logic [7:0] d; logic [7:0] rb;
    logic [6:0] ctl; logic on;} hcr_row_t;
  logic clk_sys_i = 1'b0; // System clock
  logic reset_n_i = 1'b0; // Held low at start
  logic [6:0] addr;
  logic [7:0] wdata, rdata, ev_lo = 8'h00, ev_hi = 8'h00;
  logic wr, rd, rvalid, srst, tw, lsb, bg, bias, cpd, ret, dll, irq;
  logic aed_en = 1'b0, aed_valid = 1'b0; // Checker enable and sample strobe
  logic [9:0] code = 10'h2a5, full_scale_current; // Programmed and delivered full scale
  logic [1:0] frm;
  logic [6:0] ctl;
  int failures = 0, total_checks = 0, cycles = 0, n;
  // Cumulative control state expected after each write
  hcr_row_t rows[8] = '{'{OFF_PORT, 8'h40, 8'h42, 7'h20, 1'b0},
    '{OFF_PWR, 8'ha5, 8'had, 7'h3d, 1'b1}, '{OFF_IEN_LO, 8'hff, 8'hef, 7'h3d, 1'b1},
    '{OFF_IEN_HI, 8'hff, 8'hfc, 7'h3d, 1'b1}, '{OFF_FRAME, 8'hff, 8'h03, 7'h3d, 1'b1},
    '{7'h02, 8'hff, 8'h00, 7'h3d, 1'b1}, '{OFF_IST_LO, 8'hff, 8'h00, 7'h3d, 1'b1},
    '{OFF_PWR, 8'h42, 8'h4a, 7'h22, 1'b0}};
  logic [7:0] rst_vals[8] = '{8'h81, 8'h48, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  assign ctl = {tw, lsb, bg, bias, cpd, ret, dll};

  always #2.5 clk_sys_i = ~clk_sys_i;

  hcr_host_model host (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .rvalid_i(rvalid),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  hcr_regs dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .fifo_two_slot_warning_i(ev_lo[7]),
    .fifo_one_slot_warning_i(ev_lo[6]), .serial_frame_acknowledge_i(ev_lo[5]),
    .dll_warning_i(ev_lo[3]), .dll_lock_i(ev_lo[2]), .retimer_lost_i(ev_lo[1]),
    .retimer_lock_i(ev_lo[0]), .automatic_error_checker_enable_i(aed_en),
    .automatic_error_checker_valid_i(aed_valid), .automatic_error_checker_fail_i(ev_hi[5]),
    .sample_error_checker_fail_i(ev_hi[4]), .parity_fall_error_i(ev_hi[3]),
    .parity_rise_error_i(ev_hi[2]), .full_scale_code_i(code), .three_wire_mode_o(tw),
    .lsb_first_o(lsb), .software_reset_o(srst), .bandgap_power_down_o(bg),
    .bias_power_down_o(bias), .clock_path_power_down_o(cpd),
    .retimer_pll_power_down_o(ret), .receiver_loop_power_down_o(dll),
    .full_scale_current_o(full_scale_current), .frame_pin_mode_o(frm), .interrupt_request_o(irq));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Read one register and compare the byte and its valid pulse
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.read_reg(a, d, ok);
    chk("read valid", 10'h001, {9'h000, ok});
    chk("read data", {2'h0, e}, {2'h0, d});
  endtask

  // One-cycle event, then two edges for the flag and the request to land
  task automatic pulse(input logic [7:0] lo, input logic [7:0] hi);
    @(negedge clk_sys_i);
    ev_lo = lo;
    ev_hi = hi;
    @(negedge clk_sys_i);
    ev_lo = 8'h00;
    ev_hi = 8'h00;
    repeat (2) @(negedge clk_sys_i);
  endtask

  // Enabled source: raise, read, clear by writing one, confirm quiet
  task automatic ev_case(input logic [6:0] a, input logic [7:0] m);
    if (a == OFF_IST_LO) pulse(m, 8'h00);
    else pulse(8'h00, m);
    chk("irq raised", 10'h001, {9'h000, irq});
    rd_chk(a, m);
    host.write_reg(a, m);
    rd_chk(a, 8'h00);
    chk("irq dropped", 10'h000, {9'h000, irq});
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    foreach (rows[i]) begin
      host.write_reg(rows[i].a, rows[i].d);
      rd_chk(rows[i].a, rows[i].rb);
      chk("ctl", {3'h0, rows[i].ctl}, {3'h0, ctl});
      chk("full scale", rows[i].on ? code : 10'h000, full_scale_current);
    end
    chk("frame mode", 10'h003, {8'h00, frm});
    $display("table test done");
    // Soft reset: one pulse, then every register back at its reset value
    host.write_reg(OFF_PORT, 8'h20);
    n = 0;
    for (int k = 0; k < 4; k++) begin
      if (srst === 1'b1) n++;
      @(negedge clk_sys_i);
    end
    chk("soft reset pulse", 10'h001, n[9:0]);
    for (logic [6:0] a = 7'h00; a < 7'h08; a++) rd_chk(a, rst_vals[a[2:0]]);
    chk("controls", 10'h040, {3'h0, ctl});
    chk("frame mode", 10'h000, {8'h00, frm});
    $display("soft reset test done");
    // Masked source flags but does not interrupt until enabled
    pulse(8'h80, 8'h00);
    chk("irq masked", 10'h000, {9'h000, irq});
    rd_chk(OFF_IST_LO, 8'h80);
    host.write_reg(OFF_IEN_LO, 8'h80);
    repeat (3) @(negedge clk_sys_i);
    chk("irq unmasked", 10'h001, {9'h000, irq});
    host.write_reg(OFF_IST_LO, 8'h80);
    host.write_reg(OFF_IEN_LO, 8'hef);
    host.write_reg(OFF_IEN_HI, 8'h7c);
    for (int i = 0; i < 8; i++) if (i != 4) ev_case(OFF_IST_LO, 8'h01 << i);
    for (int i = 2; i < 6; i++) ev_case(OFF_IST_HI, 8'h01 << i);
    // Retimer loss and receiver warning in the same cycle both land
    pulse(8'h0a, 8'h00);
    rd_chk(OFF_IST_LO, 8'h0a);
    host.write_reg(OFF_IST_LO, 8'h0a);
    // Acknowledge held high sets once only
    @(negedge clk_sys_i);
    ev_lo = 8'h20;
    repeat (3) @(negedge clk_sys_i);
    host.write_reg(OFF_IST_LO, 8'h20);
    rd_chk(OFF_IST_LO, 8'h00);
    ev_lo = 8'h00;
    $display("event test done");
    // Seven valid samples are not enough, the eighth passes
    aed_en = 1'b1;
    repeat (7) pulse(8'h00, 8'h00) ;
    for (int k = 0; k < 8; k++) begin
      @(negedge clk_sys_i);
      aed_valid = 1'b1;
      @(negedge clk_sys_i);
      aed_valid = 1'b0;
      if (k == 6) rd_chk(OFF_IST_HI, 8'h00);
    end
    repeat (2) @(negedge clk_sys_i);
    rd_chk(OFF_IST_HI, 8'h40);
    chk("irq on pass", 10'h001, {9'h000, irq});
    aed_en = 1'b0;
    $display("sample tally test done");
    // Hardware reset in mid-run; mode moved off its reset value first
    host.write_reg(OFF_PORT, 8'h40);
    @(negedge clk_sys_i);
    reset_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    rd_chk(OFF_IEN_LO, 8'h00);
    chk("controls", 10'h040, {3'h0, ctl});
    chk("irq after reset", 10'h000, {9'h000, irq});
    $display("hardware reset test done");
    wrap_up();
  end
endmodule
